/* rtl/cmb_memory_bus.sv */
/*
 * Processor memory bus front end: vector address generation, reset,
 * load, interrupt and trap context switches, and the general access port.
 * Assumes the core keeps acc_req high until acc_done, and that external
 * glue forms READY from wait_ind and the slow region select.
 */
module cmb_memory_bus
    import cmb_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // Context switch requests
    input  wire logic                  restart_req_n,
    input  wire logic                  int_req,
    input  wire logic [3:0]            int_level,
    input  wire logic                  xop_req,
    input  wire logic [3:0]            xop_num,
    input  wire logic [15:0]           status_word,
    input  wire logic [15:0]           cur_program_counter,
    input  wire logic [15:0]           cur_workspace,
    output logic                       switch_done,
    output logic [15:0]                new_workspace,
    output logic [15:0]                new_program_counter,
    // General access port
    input  wire logic                  acc_req,
    input  wire logic                  acc_write,
    input  wire logic [15:0]           acc_addr,
    input  wire logic [15:0]           acc_wdata,
    output logic                       acc_done,
    output logic [15:0]                acc_rdata,
    // Memory bus pins
    input  wire logic                  ready,
    output logic                       mem_cycle_strobe_n,
    output logic                       bus_input_direction,
    output logic                       write_strobe_n,
    output logic                       wait_ind,
    output logic [CMB_ADDR_W-1:0]      address_lines,
    output logic [15:0]                data_lines_o,
    output logic                       data_lines_oe_n,
    input  wire logic [15:0]           data_lines_i
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // READY is built by glue from our own registered pins on ref_clk,
    logic [1:0]  ld_s_q;
    logic [15:0] din_s1_q;
    logic [15:0] din_s2_q;

    // Two stage capture of asynchronous pins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // so it is same-domain and must reach phase one without delay
            ld_s_q   <= 2'h3;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end else begin
            // Restart request and data pins cross in from outside
            ld_s_q   <= {ld_s_q[0], restart_req_n};
            din_s1_q <= data_lines_i;
            din_s2_q <= din_s1_q;
        end
    end

    // ********************************************************
    // Vector address arithmetic
    // ********************************************************

    // Byte address of the word pair for a source
    function automatic logic [15:0] cmb_vec_addr(input cmb_src_t src, input logic [3:0] idx);
        logic [15:0] a;
        a = 16'h0000;
        unique case (src)
            CMB_SRC_RESET: a = CMB_RESET_VEC;
            CMB_SRC_INT:   a = CMB_INT_VEC_BASE + {10'h000, idx, 2'h0};
            CMB_SRC_XOP:   a = CMB_XOP_VEC_BASE + {10'h000, idx, 2'h0};
            CMB_SRC_LOAD:  a = CMB_LOAD_VEC;
        endcase
        return a;
    endfunction

    // ********************************************************
    // Context switch sequencer
    // ********************************************************
    cmb_seq_t    seq_q;
    cmb_src_t    src_q;
    logic [3:0]  idx_q;
    logic [15:0] vec_q;
    logic [15:0] old_st_q;
    logic [15:0] old_pc_q;
    logic [15:0] old_wp_q;
    logic        rst_pend_q;
    logic        use_acc_q;

    // Cycle engine request mux
    logic        c_req;
    logic        c_wr;
    logic [15:0] c_addr;
    logic [15:0] c_wdata;
    logic        c_done;
    logic [15:0] c_rdata;

    // Choose what the engine runs this cycle
    always_comb begin
        c_req   = 1'b0;
        c_wr    = 1'b0;
        c_addr  = 16'h0000;
        c_wdata = 16'h0000;
        unique case (seq_q)
            CMB_SEQ_IDLE: begin
                c_req   = use_acc_q && acc_req;
                c_wr    = acc_write;
                c_addr  = acc_addr;
                c_wdata = acc_wdata;
            end
            CMB_SEQ_WP: begin
                c_req  = 1'b1;
                c_addr = vec_q;
            end
            CMB_SEQ_ST: begin
                c_req   = 1'b1;
                c_wr    = 1'b1;
                c_addr  = new_workspace + CMB_R15_OFS;
                c_wdata = old_st_q;
            end
            CMB_SEQ_PC: begin
                c_req   = 1'b1;
                c_wr    = 1'b1;
                c_addr  = new_workspace + CMB_R14_OFS;
                c_wdata = old_pc_q;
            end
            CMB_SEQ_WPS: begin
                c_req   = 1'b1;
                c_wr    = 1'b1;
                c_addr  = new_workspace + CMB_R13_OFS;
                c_wdata = old_wp_q;
            end
            CMB_SEQ_NPC: begin
                c_req  = 1'b1;
                c_addr = vec_q + CMB_WORD_STEP;
            end
            default: begin
                c_req = 1'b0;
            end
        endcase
    end

    // Start and step the context switch; reset has top priority
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seq_q       <= CMB_SEQ_IDLE;
            src_q       <= CMB_SRC_RESET;
            idx_q       <= 4'h0;
            vec_q       <= 16'h0000;
            old_st_q    <= 16'h0000;
            old_pc_q    <= 16'h0000;
            old_wp_q    <= 16'h0000;
            rst_pend_q  <= 1'b1;
            use_acc_q   <= 1'b0;
            switch_done <= 1'b0;
        end else begin
            switch_done <= 1'b0;
            if (seq_q == CMB_SEQ_IDLE && !use_acc_q) begin
                if (rst_pend_q) begin
                    rst_pend_q <= 1'b0;
                    src_q      <= CMB_SRC_RESET;
                    vec_q      <= cmb_vec_addr(CMB_SRC_RESET, 4'h0);
                    seq_q      <= CMB_SEQ_WP;
                end else if (!ld_s_q[1]) begin
                    src_q <= CMB_SRC_LOAD;
                    vec_q <= cmb_vec_addr(CMB_SRC_LOAD, 4'h0);
                    seq_q <= CMB_SEQ_WP;
                end else if (int_req && int_level != 4'h0) begin
                    src_q <= CMB_SRC_INT;
                    idx_q <= int_level;
                    vec_q <= cmb_vec_addr(CMB_SRC_INT, int_level);
                    seq_q <= CMB_SEQ_WP;
                end else if (xop_req) begin
                    src_q <= CMB_SRC_XOP;
                    idx_q <= xop_num;
                    vec_q <= cmb_vec_addr(CMB_SRC_XOP, xop_num);
                    seq_q <= CMB_SEQ_WP;
                end else if (acc_req) begin
                    use_acc_q <= 1'b1;
                end
                old_st_q <= status_word;
                old_pc_q <= cur_program_counter;
                old_wp_q <= cur_workspace;
            end else if (use_acc_q) begin
                if (c_done) begin
                    use_acc_q <= 1'b0;
                end
            end else if (c_done) begin
                unique case (seq_q)
                    CMB_SEQ_WP:  seq_q <= (src_q == CMB_SRC_RESET) ? CMB_SEQ_NPC : CMB_SEQ_ST;
                    CMB_SEQ_ST:  seq_q <= CMB_SEQ_PC;
                    CMB_SEQ_PC:  seq_q <= CMB_SEQ_WPS;
                    CMB_SEQ_WPS: seq_q <= CMB_SEQ_NPC;
                    default: begin
                        seq_q       <= CMB_SEQ_IDLE;
                        switch_done <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Capture new pointer and counter from the vector reads
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            new_workspace       <= 16'h0000;
            new_program_counter <= 16'h0000;
        end else if (c_done && !use_acc_q) begin
            if (seq_q == CMB_SEQ_WP) begin
                new_workspace <= c_rdata;
            end else if (seq_q == CMB_SEQ_NPC) begin
                new_program_counter <= c_rdata;
            end
        end
    end

    // Access port answer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_done  <= 1'b0;
            acc_rdata <= 16'h0000;
        end else begin
            acc_done <= c_done && use_acc_q;
            if (c_done && use_acc_q) begin
                acc_rdata <= c_rdata;
            end
        end
    end

    // ********************************************************
    // Machine cycle engine
    // ********************************************************
    cmb_bus_cycle u_cycle (
        .ref_clk             (ref_clk),
        .reset               (reset),
        .req                 (c_req),
        .req_write           (c_wr),
        .req_addr            (c_addr),
        .req_wdata           (c_wdata),
        .done                (c_done),
        .rdata               (c_rdata),
        .ready_in            (ready),
        .mem_cycle_strobe_n  (mem_cycle_strobe_n),
        .bus_input_direction (bus_input_direction),
        .write_strobe_n      (write_strobe_n),
        .wait_ind            (wait_ind),
        .address_lines       (address_lines),
        .data_lines_o        (data_lines_o),
        .data_lines_oe_n     (data_lines_oe_n),
        .data_lines_i        (din_s2_q)
    );

endmodule

/* rtl/cmb_pkg.sv */
/*
 * Package for the processor memory bus cycle engine: vector addresses,
 * phase encoding, machine cycle states and bus widths.
 * Assumes a single clock domain; one clock edge per bus phase.
 */
package cmb_pkg;

    // ********************************************************
    // Bus widths
    // ********************************************************
    localparam int CMB_ADDR_W = 15;
    localparam int CMB_DATA_W = 16;

    // ********************************************************
    // Dedicated vector byte addresses
    // ********************************************************
    localparam logic [15:0] CMB_RESET_VEC = 16'h0000;
    localparam logic [15:0] CMB_INT_VEC_BASE = 16'h0000;
    localparam logic [15:0] CMB_INT_VEC_LAST = 16'h003E;
    localparam logic [15:0] CMB_XOP_VEC_BASE = 16'h0040;
    localparam logic [15:0] CMB_XOP_VEC_LAST = 16'h007E;
    localparam logic [15:0] CMB_LOAD_VEC = 16'hFFFC;
    localparam logic [3:0] CMB_INT_LEVEL_MAX = 4'hF;
    localparam logic [15:0] CMB_WORD_STEP = 16'h0002;

    // ********************************************************
    // Workspace register offsets for the context save
    // ********************************************************
    localparam logic [15:0] CMB_R13_OFS = 16'h001A;
    localparam logic [15:0] CMB_R14_OFS = 16'h001C;
    localparam logic [15:0] CMB_R15_OFS = 16'h001E;

    // ********************************************************
    // Clock phases and machine cycle states
    // ********************************************************
    localparam int CMB_PHASES = 4;
    localparam logic [1:0] CMB_PH1 = 2'h0;
    localparam logic [1:0] CMB_PH2 = 2'h1;
    localparam logic [1:0] CMB_PH3 = 2'h2;
    localparam logic [1:0] CMB_PH4 = 2'h3;

    typedef enum logic [1:0] {
        CMB_IDLE,
        CMB_CLK1,
        CMB_WAIT,
        CMB_CLK2
    } cmb_cyc_t;

    // Context switch sequencer
    typedef enum logic [2:0] {
        CMB_SEQ_IDLE,
        CMB_SEQ_WP,
        CMB_SEQ_ST,
        CMB_SEQ_PC,
        CMB_SEQ_WPS,
        CMB_SEQ_NPC
    } cmb_seq_t;

    // Vector source
    typedef enum logic [1:0] {
        CMB_SRC_RESET,
        CMB_SRC_INT,
        CMB_SRC_XOP,
        CMB_SRC_LOAD
    } cmb_src_t;

endpackage

/* rtl/cmb_bus_cycle.sv */
/*
 * Single memory machine cycle engine: four phase counter, strobes,
 * READY sampling, wait state insertion and the wait indicator.
 * Assumes the requester holds its request until done pulses, and that
 * ready_in is already synchronised to ref_clk.
 */
module cmb_bus_cycle
    import cmb_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // Request side
    input  wire logic                  req,
    input  wire logic                  req_write,
    input  wire logic [15:0]           req_addr,
    input  wire logic [15:0]           req_wdata,
    output logic                       done,
    output logic [15:0]                rdata,
    // Bus pins
    input  wire logic                  ready_in,
    output logic                       mem_cycle_strobe_n,
    output logic                       bus_input_direction,
    output logic                       write_strobe_n,
    output logic                       wait_ind,
    output logic [cmb_pkg::CMB_ADDR_W-1:0] address_lines,
    output logic [15:0]                data_lines_o,
    output logic                       data_lines_oe_n,
    input  wire logic [15:0]           data_lines_i
);

    cmb_cyc_t   cyc_q;
    logic [1:0] ph_q;
    logic       turn_q;   // Extra clock after a read before any write
    logic       rdy_q;    // READY as last sampled on phase one

    // ********************************************************
    // Phase counter and cycle state
    // ********************************************************

    // Four phases per clock cycle; every state change lands on phase one
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ph_q <= CMB_PH1;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // Machine cycle sequencing with READY only looked at on phase one
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cyc_q <= CMB_IDLE;
        end else if (ph_q == CMB_PH4) begin
            unique case (cyc_q)
                CMB_IDLE: begin
                    if (req && !done && !(req_write && turn_q)) begin
                        cyc_q <= CMB_CLK1;
                    end
                end
                CMB_CLK1, CMB_WAIT: begin
                    cyc_q <= rdy_q ? CMB_CLK2 : CMB_WAIT;
                end
                CMB_CLK2: begin
                    cyc_q <= CMB_IDLE;
                end
            endcase
        end
    end

    // READY captured on phase one of clock cycle 1 and of each wait state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdy_q <= 1'b0;
        end else if (ph_q == CMB_PH1 && (cyc_q == CMB_CLK1 || cyc_q == CMB_WAIT)) begin
            rdy_q <= ready_in;
        end
    end

    // ********************************************************
    // Bus strobes, address and data
    // ********************************************************

    // Strobes and drivers follow the state; held unchanged in wait states
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_cycle_strobe_n  <= 1'b1;
            bus_input_direction <= 1'b0;
            write_strobe_n      <= 1'b1;
            address_lines       <= '0;
            data_lines_o        <= 16'h0000;
            data_lines_oe_n     <= 1'b1;
        end else if (ph_q == CMB_PH4 && cyc_q == CMB_IDLE && req && !done
                     && !(req_write && turn_q)) begin
            mem_cycle_strobe_n  <= 1'b0;
            bus_input_direction <= !req_write;
            address_lines       <= req_addr[15:1];
            data_lines_o        <= req_wdata;
            data_lines_oe_n     <= !req_write;
        end else if (ph_q == CMB_PH4 && cyc_q == CMB_CLK2) begin
            mem_cycle_strobe_n  <= 1'b1;
            bus_input_direction <= 1'b0;
            data_lines_oe_n     <= 1'b1;
        end
        // Write pulse: low from phase one of clock 1 to phase one of clock 2
        if (!reset) begin
            if (ph_q == CMB_PH4 && cyc_q == CMB_IDLE && req && req_write && !done && !turn_q) begin
                write_strobe_n <= 1'b0;
            end else if (ph_q == CMB_PH4 && (cyc_q == CMB_CLK1 || cyc_q == CMB_WAIT) && rdy_q) begin
                write_strobe_n <= 1'b1;
            end
        end
    end

    // Read data captured on phase one of clock cycle 2
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata <= 16'h0000;
            done  <= 1'b0;
        end else begin
            done <= (cyc_q == CMB_CLK2 && ph_q == CMB_PH4);
            if (cyc_q == CMB_CLK2 && ph_q == CMB_PH1 && bus_input_direction) begin
                rdata <= data_lines_i;
            end
        end
    end

    // Turnaround after a read: writes held off one more clock cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            turn_q <= 1'b0;
        end else if (ph_q == CMB_PH4) begin
            turn_q <= (cyc_q == CMB_CLK2 && bus_input_direction);
        end
    end

    // Wait indicator changes on phase three; rises in the clock whose READY was low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_ind <= 1'b0;
        end else if (ph_q == CMB_PH2) begin
            wait_ind <= (cyc_q == CMB_CLK1 || cyc_q == CMB_WAIT) && !rdy_q;
        end
    end

endmodule

/* testbench/cmb_memory_bus_chk.sv */
/* Checker on the memory bus pins of cmb_memory_bus.
   Assumes one clock domain and a synchronous reset; bound below. */
module cmb_bus_chk
    import cmb_pkg::*;
(
    // Clock and reset
    input wire logic                          ref_clk,
    input wire logic                          reset,
    // Bus pins
    input wire logic                          mem_cycle_strobe_n,
    input wire logic                          bus_input_direction,
    input wire logic                          write_strobe_n,
    input wire logic                          wait_ind,
    input wire logic                          data_lines_oe_n,
    input wire logic [cmb_pkg::CMB_ADDR_W-1:0] address_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock, one reset for every check
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Strobe, direction and wait state relations
    chk_dir_in_read: assert property (bus_input_direction |-> !mem_cycle_strobe_n && data_lines_oe_n)
        else $error("direction high outside cycle or drivers on");
    chk_we_in_write: assert property (!write_strobe_n |-> !mem_cycle_strobe_n && !bus_input_direction)
        else $error("write strobe outside a write cycle");
    chk_we_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe shorter than one clock");
    chk_we_early_off: assert property ($rose(write_strobe_n) |-> !mem_cycle_strobe_n)
        else $error("write strobe not released inside the cycle");
    chk_cycle_min: assert property ($fell(mem_cycle_strobe_n) |-> !mem_cycle_strobe_n [*8])
        else $error("memory cycle shorter than two clocks");
    chk_cycle_bound: assert property ($fell(mem_cycle_strobe_n) |-> ##[8:40] $rose(mem_cycle_strobe_n))
        else $error("memory cycle did not finish");
    chk_wait_len: assert property ($rose(wait_ind) |-> wait_ind [*4])
        else $error("wait state not one full clock");
    chk_wait_hold: assert property (wait_ind |-> !mem_cycle_strobe_n && $stable(address_lines))
        else $error("outputs moved during a wait state");
    chk_rd_gap: assert property ($fell(bus_input_direction) |-> data_lines_oe_n [*4])
        else $error("data drivers on too soon after a read");
endmodule

bind cmb_memory_bus cmb_bus_chk CHK (.ref_clk(ref_clk), .reset(reset), .mem_cycle_strobe_n(mem_cycle_strobe_n),
    .bus_input_direction(bus_input_direction), .write_strobe_n(write_strobe_n), .wait_ind(wait_ind),
    .data_lines_oe_n(data_lines_oe_n), .address_lines(address_lines));

/* testbench/cmb_mem_model.sv */
/* Static word memory with slow region decode and wait glue.
   Assumes it faces the cmb_memory_bus pins on the same clock. */
module cmb_mem_model
    import cmb_pkg::*;
(
    // Clock, reset and glue choice
    input wire logic                           ref_clk,
    input wire logic                           reset,
    input wire logic [1:0]                     mode,
    // Bus pins
    input wire logic [cmb_pkg::CMB_ADDR_W-1:0] address_lines,
    input wire logic                           mem_cycle_strobe_n,
    input wire logic                           bus_input_direction,
    input wire logic                           write_strobe_n,
    input wire logic                           wait_ind,
    input wire logic [15:0]                    data_lines_o,
    input wire logic                           data_lines_oe_n,
    output logic                               ready,
    output logic [15:0]                        data_lines_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    logic [15:0] last_q = 16'h0000;
    logic [3:0]  wait_dly_q;
    logic        we_q;
    logic        slow_region_sel_n;
    logic        write_level;
    // Upper half is the slow region
    assign slow_region_sel_n = ~address_lines[CMB_ADDR_W-1];
    assign write_level = ~(mem_cycle_strobe_n | bus_input_direction);
    // Glue: no wait, gated wait indicator, or indicator delayed one clock
    always_comb begin
        case (mode)
            2'h1: ready = slow_region_sel_n | wait_ind;
            2'h2: ready = slow_region_sel_n | wait_dly_q[3];
            default: ready = 1'b1;
        endcase
    end
    // Data only while turned in; otherwise a pattern that moves each cycle
    assign data_lines_i = bus_input_direction ? mem[address_lines] : ~last_q;
    // Write lands at the end of the pulse; undriven data is stored corrupted
    always @(posedge ref_clk) begin
        last_q <= data_lines_i;
        we_q <= write_strobe_n;
        wait_dly_q <= reset ? 4'h0 : {wait_dly_q[2:0], wait_ind};
        if (write_level && write_strobe_n && !we_q) begin
            mem[address_lines] <= data_lines_oe_n ? ~data_lines_o : data_lines_o;
        end
    end
endmodule

/* testbench/cmb_memory_bus_tb.sv */
/* Self-checking bench: vectors, context saves and bus cycle lengths.
   Assumes the checker binds itself and the memory model holds the image. */
module cmb_memory_bus_tb;
    import cmb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset, restart_req_n, int_req, xop_req, acc_req, acc_write, switch_done, acc_done, ready;
    logic mem_cycle_strobe_n, bus_input_direction, write_strobe_n, wait_ind, data_lines_oe_n;
    logic [3:0] int_level, xop_num;
    logic [1:0] mode;
    logic [15:0] status_word, cur_program_counter, cur_workspace, acc_addr, acc_wdata, acc_rdata;
    logic [15:0] new_workspace, new_program_counter, data_lines_o, data_lines_i, a, d, rd;
    logic [CMB_ADDR_W-1:0] address_lines;
    int num_errors = 0;
    int cmp_count = 0;
    int n;

    always #2.5 ref_clk = ~ref_clk;
    cmb_memory_bus DUT (.*);
    cmb_mem_model PART (.*);

    // Memory image: pointer words even, counter words odd
    function automatic logic [15:0] word_init(input logic [14:0] i);
        return i[0] ? ~{i, 1'b0} : {4'h1, i[6:0], 5'h00};
    endfunction
    // Expected wait states for a glue mode and address
    function automatic int waits(input logic [1:0] m, input logic [15:0] ad);
        return (m == 2'h0 || !ad[15]) ? 0 : int'(m);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One access; n counts cycles with the strobe low
    task automatic access(input logic w, input logic [15:0] ad, input logic [15:0] wd);
        acc_req = 1'b1;
        acc_write = w;
        acc_addr = ad;
        acc_wdata = wd;
        n = 0;
        for (int k = 0; k < 300 && acc_done !== 1'b1; k++) begin
            @(negedge ref_clk);
            n += int'(mem_cycle_strobe_n === 1'b0);
        end
        rd = acc_rdata;
        check(acc_done, 16'h0001, "access done");
        acc_req = 1'b0;
        @(negedge ref_clk);
    endtask

    // Kind 0 interrupt, 1 trap, 2 restart; checks vector and saved state
    task automatic switch_chk(input int kind, input logic [3:0] num);
        logic [15:0] vec;
        logic [15:0] ws;
        vec = (kind == 2) ? CMB_LOAD_VEC : {9'h000, kind == 1, num, 2'h0};
        status_word = $urandom;
        cur_program_counter = 16'($urandom) & 16'hFFFE;
        cur_workspace = 16'($urandom) & 16'hFFFE;
        mode = 2'($urandom % 3);
        int_level = num;
        xop_num = num;
        int_req = (kind == 0);
        xop_req = (kind == 1);
        restart_req_n = (kind != 2);
        for (int k = 0; k < 400 && switch_done !== 1'b1; k++) begin
            @(negedge ref_clk);
        end
        int_req = 1'b0;
        xop_req = 1'b0;
        restart_req_n = 1'b1;
        check(new_workspace, word_init(vec[15:1]), "new pointer");
        check(new_program_counter, word_init(vec[15:1] + 15'h0001), "new counter");
        ws = word_init(vec[15:1]) + CMB_R15_OFS;
        check(PART.mem[ws[15:1]], status_word, "saved status");
        ws = word_init(vec[15:1]) + CMB_R14_OFS;
        check(PART.mem[ws[15:1]], cur_program_counter, "saved counter");
        ws = word_init(vec[15:1]) + CMB_R13_OFS;
        check(PART.mem[ws[15:1]], cur_workspace, "saved pointer");
        repeat (200) @(negedge ref_clk);
    endtask

    initial begin
        reset = 1'b1;
        {restart_req_n, int_req, xop_req, acc_req, acc_write} = 5'h10;
        {int_level, xop_num, mode} = 10'h000;
        {status_word, cur_program_counter, cur_workspace, acc_addr, acc_wdata} = 80'h0;
        n = $urandom(54199);
        for (int i = 0; i < 32768; i++) begin
            PART.mem[i] = word_init(15'(i));
        end
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        for (int k = 0; k < 400 && switch_done !== 1'b1; k++) begin
            @(negedge ref_clk);
        end
        check(new_workspace, word_init(15'h0000), "reset pointer");
        check(new_program_counter, word_init(15'h0001), "reset counter");
        repeat (20) @(negedge ref_clk);
        $display("test reset vector done");
        for (int i = 0; i < 32; i++) begin
            switch_chk(i < 15 ? 0 : (i < 31 ? 1 : 2), i < 15 ? 4'(i + 1) : 4'(i - 15));
        end
        $display("test context switches done");
        for (int i = 0; i < 40; i++) begin
            mode = (i < 4) ? 2'(i % 3 + i / 3) : 2'($urandom % 3);
            a = (i < 3) ? 16'hFFFE : ((i == 3) ? 16'h7FFE : 16'($urandom));
            d = $urandom;
            access(1'b1, a, d);
            check(16'(n), 16'(8 + 4 * waits(mode, a)), "write length");
            access(1'b0, a, 16'h0000);
            check(16'(n), 16'(8 + 4 * waits(mode, a)), "read length");
            check(rd, d, "read back");
        end
        $display("test access cycles done");
        complete_run();
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule
